// ### hdl/hbspi_ctrl.sv
// Half-bridge serial control, protection and dead-time sequencing
// Summary of operation
// - Overcurrent held past delay cuts that switch
// - Cut switch reads inactive, overload flag set
// - Cutoff disabled keeps output current limited
// - Control bit 13 enables overcurrent cutoff
// - Hard short flagged, output stays limited
// - Prewarning sets status bit 0, outputs run
// - Thermal shutdown cuts all, sets overload
// - Filtered open load sets underload bit 14
// - Control bit 14 cuts open-load switch
// - Status bits 1-12 show real switch states
// - Chip select falling starts 16-bit transfer
// - Input bits captured on serial clock rise
// - Previous status shifted out during transfer
// - Chip select rise after 16 bits applies received word
// - Dead time prevents bridge cross conduction
// - Freewheel transistor on during demagnetisation
// - Low-side one bit turns that switch on
// - Control bit 0 clears overload, underload and supply flags
// - Serial output released when deselected
// - Bit 15 enables overvoltage cutoff
// - Prewarning clears only below recovery threshold
module hbspi_ctrl #(
    parameter int SWITCHES = 12,
    parameter int OL_FILTER_CYC = hbspi_pkg::OL_FILTER_CYC
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Serial link, its own clock domain
    input wire logic serial_clk,
    input wire logic chip_select_low,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_en,
    // Analog comparators, asynchronous
    input wire logic [11:0] overcurrent_cmp,
    input wire logic [11:0] hard_short_cmp,
    input wire logic [11:0] open_load_cmp,
    input wire logic [11:0] demag_cmp,
    input wire logic temp_warn_cmp,
    input wire logic temp_recover_cmp,
    input wire logic temp_shutdown_cmp,
    input wire logic overvoltage_cmp,
    input wire logic undervoltage_cmp,
    // Gate drive: even index low side, odd index high side
    output logic [11:0] gate_on,
    output logic [11:0] current_limit,
    output logic [15:0] control_word
);
    localparam int CW = hbspi_pkg::CNT_W;

    // Link domain: shift register and received word
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0] bit_cnt;
    logic [15:0] rx_word;
    logic rx_toggle;
    logic out_bit;
    logic cs_sync1, cs_sync2;
    // Status image frozen while selected, read by the link side
    logic [15:0] status_hold;
    logic [15:0] status_word;

    // Capture on rising serial clock, MSB first
    always_ff @(posedge serial_clk)
    begin
        if (!chip_select_low)
        begin
            rx_shift <= {rx_shift[14:0], serial_in};
        end
    end

    // Bit count restarts with each selection
    always_ff @(posedge serial_clk or posedge chip_select_low)
    begin
        if (chip_select_low)
            bit_cnt <= 5'h00;
        else if (bit_cnt != 5'h10)
            bit_cnt <= bit_cnt + 5'h01;
    end

    // Status reaches this side through status_hold, which the system
    // side freezes while selected; the link clock only runs in frames,
    // so a synchroniser here would hand over a stale image.

    // Output changes on falling edge, previous status shifted out
    always_ff @(negedge serial_clk or posedge chip_select_low)
    begin
        if (chip_select_low)
            out_bit <= 1'b0;
        else
            out_bit <= (bit_cnt == 5'h00) ? status_hold[15]
                : tx_shift[15];
    end

    always_ff @(negedge serial_clk)
    begin
        // Loaded at the first fall, so the second fall shows bit 14
        if (bit_cnt == 5'h00)
            tx_shift <= {status_hold[14:0], 1'b0};
        else
            tx_shift <= {tx_shift[14:0], 1'b0};
    end

    // Word latched on chip select rise, event passed as toggle
    // The toggle needs a known start, else no apply is ever seen
    always_ff @(posedge chip_select_low or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_word <= hbspi_pkg::CTL_RESET;
            rx_toggle <= 1'b0;
        end
        else if (bit_cnt == 5'h10)
        begin
            rx_word <= rx_shift;
            rx_toggle <= ~rx_toggle;
        end
    end

    assign serial_out = out_bit;
    assign serial_out_en = ~chip_select_low;

    // System domain: synchronise toggle and comparators
    logic tog_s1, tog_s2, tog_s3;
    logic [11:0] oc_s1, oc_s2, hs_s1, hs_s2, ol_s1, ol_s2, dm_s1, dm_s2;
    logic [4:0] misc_s1, misc_s2;
    always_ff @(posedge ref_clk)
    begin
        tog_s1 <= rx_toggle;
        tog_s2 <= tog_s1;
        tog_s3 <= tog_s2;
        oc_s1 <= overcurrent_cmp;
        oc_s2 <= oc_s1;
        hs_s1 <= hard_short_cmp;
        hs_s2 <= hs_s1;
        ol_s1 <= open_load_cmp;
        ol_s2 <= ol_s1;
        dm_s1 <= demag_cmp;
        dm_s2 <= dm_s1;
        misc_s1 <= {temp_warn_cmp, temp_recover_cmp, temp_shutdown_cmp,
                    overvoltage_cmp, undervoltage_cmp};
        misc_s2 <= misc_s1;
    end

    // Deselect seen in this domain; status refreshed only then
    always_ff @(posedge ref_clk)
    begin
        cs_sync1 <= chip_select_low;
        cs_sync2 <= cs_sync1;
    end

    // Frozen during a frame so the shifted image never tears;
    // the master must wait two clocks after selecting
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            status_hold <= hbspi_pkg::STATUS_RESET;
        else if (cs_sync2)
            status_hold <= status_word;
    end

    wire word_apply = tog_s2 ^ tog_s3;
    wire warn = misc_s2[4];
    wire recovered = misc_s2[3];
    wire tsd = misc_s2[2];
    wire ov = misc_s2[1];
    wire uv = misc_s2[0];

    // Active control register
    logic [15:0] ctl;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctl <= hbspi_pkg::CTL_RESET;
        else if (word_apply)
            ctl <= rx_word;
    end
    assign control_word = ctl;

    wire oc_en = ctl[hbspi_pkg::CTL_OC_EN];
    wire ul_en = ctl[hbspi_pkg::CTL_UL_EN];
    wire ov_en = ctl[hbspi_pkg::CTL_OV_EN];
    wire clr_req = word_apply & rx_word[hbspi_pkg::CTL_STATUS_CLR];
    wire global_off = tsd | (ov_en & ov);

    // Commanded state: high-side bits are active low in the word
    logic [11:0] cmd_on;
    always_comb
    begin
        for (int i = 0; i < SWITCHES; i++)
            cmd_on[i] = (i % 2 == 0) ? ctl[i + 1] : ~ctl[i + 1];
    end

    // Per-switch fault latches and timers
    logic [11:0] oc_trip, ol_trip, ol_flag;
    logic [CW-1:0] oc_cnt [12];
    logic [CW-1:0] ol_cnt [12];
    logic [11:0] req_on;

    // Overcurrent dwell timer, runs only while the switch conducts;
    // saturates so a long overload cannot wrap and re-arm
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < SWITCHES; i++)
        begin
            if (sys_rst || !gate_on[i] || !oc_s2[i])
                oc_cnt[i] <= '0;
            else if (oc_cnt[i] != CW'(hbspi_pkg::OC_DELAY_CYC))
                oc_cnt[i] <= oc_cnt[i] + 1'b1;
        end
    end

    // Open-load filter; short dips from inductive loads restart it
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < SWITCHES; i++)
        begin
            if (sys_rst || !gate_on[i] || !ol_s2[i])
                ol_cnt[i] <= '0;
            else if (ol_cnt[i] != CW'(OL_FILTER_CYC))
                ol_cnt[i] <= ol_cnt[i] + 1'b1;
        end
    end

    // Overcurrent trip; set wins over a re-arm in the same cycle
    // Any applied word re-arms, so the master retries by rewriting
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < SWITCHES; i++)
        begin
            if (sys_rst)
                oc_trip[i] <= 1'b0;
            else if (oc_en && oc_cnt[i] == CW'(hbspi_pkg::OC_DELAY_CYC))
                oc_trip[i] <= 1'b1;
            else if (word_apply)
                oc_trip[i] <= 1'b0;
        end
    end

    // Filtered open load per switch; set wins over a re-arm
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < SWITCHES; i++)
        begin
            if (sys_rst)
                ol_flag[i] <= 1'b0;
            else if (ol_cnt[i] == CW'(OL_FILTER_CYC))
                ol_flag[i] <= 1'b1;
            else if (word_apply)
                ol_flag[i] <= 1'b0;
        end
    end
    assign ol_trip = ol_flag & {12{ul_en}};
    // Current limit active on a hard short or overcurrent while the switch is on
    assign current_limit = (hs_s2 | oc_s2) & gate_on;
    assign req_on = (cmd_on & ~oc_trip & ~ol_trip) | dm_s2;

    // Dead time: a switch turns on only after its partner is off
    // Costs one microsecond on every reversal of a bridge
    logic [3:0] dead_cnt [12];
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < SWITCHES; i++)
        begin
            if (sys_rst)
            begin
                gate_on[i] <= 1'b0;
                dead_cnt[i] <= 4'h0;
            end
            else if (global_off || !req_on[i] || gate_on[i ^ 1])
            begin
                gate_on[i] <= 1'b0;
                dead_cnt[i] <= 4'h0;
            end
            else if (dead_cnt[i] != 4'(hbspi_pkg::DEAD_CYC))
                dead_cnt[i] <= dead_cnt[i] + 4'h1;
            else if (!req_on[i ^ 1] || i % 2 == 0)
                gate_on[i] <= 1'b1;
        end
    end
    // Sticky summary flags; a live fault wins over a clear request
    logic prewarn, overload, underload, supply_fail;

    // Prewarning holds until the die has cooled past recovery
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            prewarn <= 1'b0;
        else if (warn)
            prewarn <= 1'b1;
        else if (recovered)
            prewarn <= 1'b0;
    end

    // Overload: overcurrent cut, hard short or thermal shutdown
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            overload <= 1'b0;
        else if (tsd || |oc_trip || |(hs_s2 & gate_on))
            overload <= 1'b1;
        else if (clr_req)
            overload <= 1'b0;
    end

    // Underload: any filtered open load, switch known from bits 1-12
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            underload <= 1'b0;
        else if (|ol_flag)
            underload <= 1'b1;
        else if (clr_req)
            underload <= 1'b0;
    end

    // Supply fault is reported even with lockout disabled
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            supply_fail <= 1'b0;
        else if (ov || uv)
            supply_fail <= 1'b1;
        else if (clr_req)
            supply_fail <= 1'b0;
    end

    // Status word reflects real conduction state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            status_word <= hbspi_pkg::STATUS_RESET;
        else
            status_word <= {supply_fail, underload, overload,
                            gate_on, prewarn};
    end
endmodule // hbspi_ctrl

// ### hdl/hbspi_pkg.sv
// Package: constants for the half-bridge serial control and protection block
package hbspi_pkg;
    localparam int WORD_BITS = 16;
    localparam int SWITCHES = 12;
    // Control word fields
    localparam int CTL_STATUS_CLR = 0;
    localparam int CTL_SW_LO = 1;
    localparam int CTL_OC_EN = 13;
    localparam int CTL_UL_EN = 14;
    localparam int CTL_OV_EN = 15;
    // Status word fields
    localparam int ST_PREWARN = 0;
    localparam int ST_SW_LO = 1;
    localparam int ST_OVERLOAD = 13;
    localparam int ST_UNDERLOAD = 14;
    localparam int ST_SUPPLY = 15;
    // Reset values: high-side (odd) switches commanded on, protections off
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int OC_DELAY_US = 25;
    localparam int OL_FILTER_US = 350;
    localparam int DEAD_TIME_NS = 1000;
    // Longest times round down, least times round up
    localparam int OC_DELAY_CYC = OC_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int OL_FILTER_CYC = OL_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int DEAD_CYC = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 12;
endpackage

// ### tb/hbspi_ctrl_assertions.sv
// Checker: link and protection properties
module hbspi_ctrl_assertions #(
    parameter int SWITCHES = 12,
    parameter int OL_FILTER_CYC = 8
) (
    // Watched ports
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic chip_select_low,
    input wire logic serial_out_en,
    input wire logic [11:0] overcurrent_cmp,
    input wire logic [11:0] hard_short_cmp,
    input wire logic [11:0] open_load_cmp,
    input wire logic temp_shutdown_cmp,
    input wire logic overvoltage_cmp,
    input wire logic [11:0] gate_on,
    input wire logic [11:0] current_limit,
    input wire logic [15:0] control_word
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    int oc_cnt;
    int ul_cnt;
    // Dwell counters; long waits need counts, not repetition
    always_ff @(posedge ref_clk)
    begin
        oc_cnt <= (!sys_rst && overcurrent_cmp[0] && gate_on[0]
            && control_word[13]) ? oc_cnt + 1 : 0;
        ul_cnt <= (!sys_rst && open_load_cmp[0] && gate_on[0]
            && control_word[14]) ? ul_cnt + 1 : 0;
    end
    sequence s_hot; temp_shutdown_cmp [*5]; endsequence
    sequence s_ovc; (overvoltage_cmp && control_word[15]) [*5]; endsequence
    property p_rel; chip_select_low |-> !serial_out_en; endproperty
    a_rel: assert property (p_rel) else $error("out driven");
    property p_dead; ((gate_on >> 1) & gate_on & 12'h555) == 12'h000;
    endproperty
    a_dead: assert property (p_dead) else $error("cross");
    property p_apply; !$stable(control_word) |-> chip_select_low; endproperty
    a_apply: assert property (p_apply) else $error("early");
    property p_hot; s_hot |-> gate_on == 12'h000; endproperty
    a_hot: assert property (p_hot) else $error("hot on");
    property p_ov; s_ovc |-> gate_on == 12'h000; endproperty
    a_ov: assert property (p_ov) else $error("ov on");
    property p_lim; (hard_short_cmp[0] && gate_on[0]) [*4]
        |-> current_limit[0]; endproperty
    a_lim: assert property (p_lim) else $error("no limit");
    property p_oc; oc_cnt < 260; endproperty
    a_oc: assert property (p_oc) else $error("no cutoff");
    property p_ul; ul_cnt < OL_FILTER_CYC + 8; endproperty
    a_ul: assert property (p_ul) else $error("no ul cut");
endmodule // hbspi_ctrl_assertions

// ### tb/hbspi_master.sv
// Serial master model for framed control transfers
module hbspi_master (
    // Link pins
    output logic serial_clk,
    output logic chip_select_low,
    output logic serial_in,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: deselected, clock parked high
    initial
    begin
        serial_clk = 1'h1;
        serial_in = 1'h0;
        // Late rise gives the link counter a clean first clear
        #1 chip_select_low = 1'h1;
    end
    // Data moves on fall so both ends sample on rise
    task automatic xfer(input logic [15:0] tx, input int n,
        output logic [15:0] rx);
        rx = 16'h0000;
        #17 chip_select_low = 1'h0;
        #250; // Let the status image freeze first
        for (int i = 0; i < n; i++)
        begin
            #62.5 serial_clk = 1'h0;
            serial_in = tx[15 - i];
            #62.5 serial_clk = 1'h1;
            rx = {rx[14:0], serial_out};
        end
        #62.5 chip_select_low = 1'h1;
        serial_in = ~serial_in; // Released: no stale bit
        #700;
    endtask
endmodule // hbspi_master

// ### tb/half_bridge_spi_protect_ctrl_tb_top.sv
// Bench top: random words plus fault table
module half_bridge_spi_protect_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic serial_clk, chip_select_low, serial_in, serial_out, serial_out_en;
    logic [11:0] oc = 12'h000, hs = 12'h000, ol = 12'h000;
    logic [11:0] gate_on, current_limit;
    logic t_warn = 1'h0, t_sd = 1'h0, ov = 1'h0, t_rec = 1'h0;
    logic [15:0] control_word, rx, w, st;
    int n_errors = 0;
    int checked = 0;
    // Fault table: enable bit, fault pins, gate bit, flag bit
    localparam logic [15:0] EN [7] = '{16'h2000, 16'h0000, 16'h0000,
        16'h0000, 16'h4000, 16'h8000, 16'h0000};
    localparam logic [4:0] FL [7] = '{5'h01, 5'h01, 5'h08, 5'h04,
        5'h02, 5'h10, 5'h01};
    localparam logic [6:0] G0 = 7'h4A;
    localparam int SB [7] = '{13, 1, 13, 0, 14, 15, 13};
    initial forever #50 ref_clk = ~ref_clk;
    hbspi_ctrl #(.SWITCHES(12), .OL_FILTER_CYC(8)) u_dut (.ref_clk,
        .sys_rst, .serial_clk, .chip_select_low, .serial_in, .serial_out,
        .serial_out_en, .overcurrent_cmp(oc), .hard_short_cmp(hs),
        .open_load_cmp(ol), .demag_cmp(12'h000), .temp_warn_cmp(t_warn),
        .temp_recover_cmp(t_rec), .temp_shutdown_cmp(t_sd),
        .overvoltage_cmp(ov), .undervoltage_cmp(1'h0), .gate_on,
        .current_limit, .control_word);
    hbspi_master u_mst (.serial_clk, .chip_select_low, .serial_in,
        .serial_out(serial_out_en ? serial_out : 1'hZ));
    // Status image: odd switches are high sides, commanded low
    function automatic logic [15:0] exp_st(logic [15:0] c);
        exp_st = 16'h0000;
        for (int i = 0; i < 12; i++)
            exp_st[i + 1] = c[i + 1] ^ i[0];
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic end_sim;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Hang guard, well past the whole run
    initial
    begin
        #1_000_000;
        n_errors++;
        end_sim;
    end
    initial
    begin
        w = $urandom(33);
        cyc(8);
        sys_rst = 1'h0;
        cyc(20);
        st = exp_st(16'h0000);
        // Random legal words; each frame returns the last status
        for (int k = 0; k < 6; k++)
        begin
            w = 16'($urandom) & 16'h1FFE;
            w = w | ((w & 16'h0AAA) << 1);
            u_mst.xfer(w, 16, rx);
            chk(rx, st);
            cyc(20);
            chk(control_word, w);
            chk({4'h0, gate_on}, exp_st(w) >> 1);
            st = exp_st(w);
        end
        u_mst.xfer(16'h1554, 8, rx);
        cyc(10);
        chk(control_word, w);
        $display("test random done");
        // Faults on switch one, then sticky flag and clear
        for (int k = 0; k < 7; k++)
        begin
            w = 16'h1556 | EN[k];
            u_mst.xfer(w, 16, rx);
            cyc(20);
            {ov, t_sd, t_warn, ol[0], oc[0]} = FL[k];
            hs[0] = (k == 6);
            cyc(300);
            chk({15'h0, gate_on[0]}, {15'h0, G0[k]});
            {ov, t_sd, t_warn, ol[0], oc[0], hs[0]} = 6'h00;
            cyc(10);
            u_mst.xfer(w, 16, rx);
            chk({15'h0, rx[SB[k]]}, 16'h0001);
            u_mst.xfer(16'h1555, 16, rx);
            u_mst.xfer(16'h1554, 16, rx);
            chk({13'h0, rx[15:13]}, 16'h0000);
            $display("test fault %0d done", k);
        end
        // Prewarning still latched; recovery alone clears it
        t_rec = 1'h1;
        cyc(5);
        t_rec = 1'h0;
        cyc(5);
        u_mst.xfer(16'h1554, 16, rx);
        chk({15'h0, rx[0]}, 16'h0000);
        $display("test recover done");
        end_sim;
    end
endmodule // half_bridge_spi_protect_ctrl_tb_top
bind hbspi_ctrl hbspi_ctrl_assertions #(.SWITCHES(SWITCHES),
    .OL_FILTER_CYC(OL_FILTER_CYC)) u_chk (.ref_clk, .sys_rst,
    .chip_select_low, .serial_out_en, .overcurrent_cmp, .hard_short_cmp,
    .open_load_cmp, .temp_shutdown_cmp, .overvoltage_cmp, .gate_on,
    .current_limit, .control_word);
